// File: shared/palp_regs.vh
`ifndef PALP_REGS_VH
`define PALP_REGS_VH

// register byte offsets on the axi4-lite bus
`define PALP_OFF_PIN_VIEW 8'h00
`define PALP_OFF_LATCH 8'h04
`define PALP_OFF_PULLUP 8'h08
`define PALP_OFF_CTRL 8'h0c
`define PALP_OFF_STATUS 8'h10

// implemented bits of each writable register
`define PALP_LATCH_MASK 8'hdf
`define PALP_PULLUP_MASK 8'h20
`define PALP_CTRL_MASK 8'h01

// field positions
`define PALP_PIN5 5
`define PALP_CTRL_GLOBAL_OFF 0
`define PALP_STAT_EXT_RESET 8

// reset values
`define PALP_LATCH_RST 8'h00
`define PALP_PULLUP_RST 8'h20
`define PALP_CTRL_RST 8'h01

// axi response codes
`define PALP_RESP_OKAY 2'h0
`define PALP_RESP_SLVERR 2'h2

`endif

// File: rtl/palp_sync.v
`timescale 1ns/1ps

// two-stage synchroniser for levels from outside mclk
module palp_sync #(
	parameter WIDTH = 8
) (
	input wire mclk,
	input wire rstn,
	input wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_q; // first stage, read only by second
	reg [WIDTH-1:0] sync_q; // second stage, safe to use

	// both stages clear on reset, shift on every edge
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= asyncIn;
			sync_q <= meta_q;
		end
	end

	assign syncOut = sync_q;

endmodule

// File: rtl/palp_port.v
`timescale 1ns/1ps
`include "palp_regs.vh"

// Function
// (RQ1) pin data writes go to latch
// (RQ2) pin data reads return live pins
// (RQ3) latch holds bits 7:6,4:0; bit5 zero
// (RQ4) reset pin off: bit5 controls pin5 pull-up
// (RQ5) reset pin on: pin5 pull-up on unless pin5 is output
// (RQ6) global disable blocks individual pull-ups
// (RQ7) output pins never get pull-up
// (RQ8) pull-up register: bit5 only, resets one
// (RQ9) direction input gates pull-up and output enables
module palp_port #(
	parameter ADDR_W = 8
) (
	input wire mclk,
	input wire rstn,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] pinIn,
	output wire [7:0] pinOut,
	output wire [7:0] pinOe,
	output wire [7:0] pinPullup,
	input wire [7:0] pinDirOutput,
	input wire extResetPinEnable
);

	////////////////////////////////////////////////////////////////
	// register index codes
	////////////////////////////////////////////////////////////////

	localparam [2:0] IDX_PIN_VIEW = 3'h0; // pin view / latch alias
	localparam [2:0] IDX_LATCH = 3'h1; // output latch
	localparam [2:0] IDX_PULLUP = 3'h2; // pull-up enable
	localparam [2:0] IDX_CTRL = 3'h3; // global pull-up off
	localparam [2:0] IDX_STATUS = 3'h4; // effective pull-ups
	localparam [2:0] IDX_NONE = 3'h7; // unmapped

	////////////////////////////////////////////////////////////////
	// functions
	////////////////////////////////////////////////////////////////

	// address to register index, unmapped gives IDX_NONE
	function [2:0] decodeIdx;
		input [ADDR_W-1:0] addr;
		begin
			if (addr == `PALP_OFF_PIN_VIEW) begin
				decodeIdx = IDX_PIN_VIEW;
			end else if (addr == `PALP_OFF_LATCH) begin
				decodeIdx = IDX_LATCH;
			end else if (addr == `PALP_OFF_PULLUP) begin
				decodeIdx = IDX_PULLUP;
			end else if (addr == `PALP_OFF_CTRL) begin
				decodeIdx = IDX_CTRL;
			end else if (addr == `PALP_OFF_STATUS) begin
				decodeIdx = IDX_STATUS;
			end else begin
				decodeIdx = IDX_NONE;
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// state
	////////////////////////////////////////////////////////////////

	reg [7:0] outputLatchReg_q; // output latch
	reg [7:0] pullupEnableReg_q; // pull-up enable, bit5 only
	reg globalPullupOff_q; // global pull-up disable
	reg awHeld_q; // write address captured
	reg [ADDR_W-1:0] awAddr_q; // captured write address
	reg wHeld_q; // write data captured
	reg [7:0] wData_q; // captured write byte
	reg wLane_q; // captured byte-0 strobe
	reg bvalid_q; // write response pending
	reg [1:0] bresp_q; // write response code
	reg rvalid_q; // read response pending
	reg [31:0] rdata_q; // read data
	reg [1:0] rresp_q; // read response code
	reg [7:0] pinPullup_q; // registered pull-up drive

	wire [7:0] pinLevel; // synchronised pin levels
	wire extResetSync; // synchronised reset-pin config

	////////////////////////////////////////////////////////////////
	// input synchronisers
	////////////////////////////////////////////////////////////////

	// pins come from the board, so two flops first
	palp_sync #(
		.WIDTH(8)
	) pinSyncInst (
		.mclk(mclk),
		.rstn(rstn),
		.asyncIn(pinIn),
		.syncOut(pinLevel)
	);

	// configuration level is static but still crosses in
	palp_sync #(
		.WIDTH(1)
	) cfgSyncInst (
		.mclk(mclk),
		.rstn(rstn),
		.asyncIn(extResetPinEnable),
		.syncOut(extResetSync)
	);

	////////////////////////////////////////////////////////////////
	// write channel handshake
	////////////////////////////////////////////////////////////////

	wire awFire; // address taken this edge
	wire wFire; // data taken this edge
	wire doWrite; // both halves present
	wire [ADDR_W-1:0] wrAddr; // effective write address
	wire [7:0] wrByte; // effective write byte
	wire wrLane; // effective byte-0 strobe
	wire [2:0] wrIdx; // decoded write target

	// ready drops once a half is held or response waits
	assign s_axi_awready = ~awHeld_q & ~bvalid_q;
	assign s_axi_wready = ~wHeld_q & ~bvalid_q;
	assign awFire = s_axi_awvalid & s_axi_awready;
	assign wFire = s_axi_wvalid & s_axi_wready;
	assign doWrite = (awFire | awHeld_q) & (wFire | wHeld_q);
	assign wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
	assign wrByte = wHeld_q ? wData_q : s_axi_wdata[7:0];
	assign wrLane = wHeld_q ? wLane_q : s_axi_wstrb[0];
	assign wrIdx = decodeIdx(wrAddr);

	// hold whichever half arrives first, answer once both are in
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			awHeld_q <= 1'b0;
			awAddr_q <= {ADDR_W{1'b0}};
			wHeld_q <= 1'b0;
			wData_q <= 8'h00;
			wLane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `PALP_RESP_OKAY;
		end else begin
			if (doWrite) begin
				// both halves complete: release and respond
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (wrIdx == IDX_NONE) ? `PALP_RESP_SLVERR : `PALP_RESP_OKAY;
			end else begin
				// park a lone half until its partner comes
				if (awFire) begin
					awHeld_q <= 1'b1;
					awAddr_q <= s_axi_awaddr;
				end
				if (wFire) begin
					wHeld_q <= 1'b1;
					wData_q <= s_axi_wdata[7:0];
					wLane_q <= s_axi_wstrb[0];
				end
				if (bvalid_q && s_axi_bready) begin
					bvalid_q <= 1'b0;
				end
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	////////////////////////////////////////////////////////////////
	// software registers
	////////////////////////////////////////////////////////////////

	// writes land on byte lane 0; unimplemented bits stay zero
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			outputLatchReg_q <= `PALP_LATCH_RST;
			pullupEnableReg_q <= `PALP_PULLUP_RST; // RQ8
			globalPullupOff_q <= 1'b1;
		end else if (doWrite && wrLane) begin
			if (wrIdx == IDX_PIN_VIEW) begin
				// pin data writes never touch pins directly
				outputLatchReg_q <= wrByte & `PALP_LATCH_MASK; // RQ1 RQ3
			end else if (wrIdx == IDX_LATCH) begin
				outputLatchReg_q <= wrByte & `PALP_LATCH_MASK; // RQ3
			end else if (wrIdx == IDX_PULLUP) begin
				pullupEnableReg_q <= wrByte & `PALP_PULLUP_MASK; // RQ8
			end else if (wrIdx == IDX_CTRL) begin
				globalPullupOff_q <= wrByte[`PALP_CTRL_GLOBAL_OFF];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// pull-up control
	////////////////////////////////////////////////////////////////

	reg [7:0] pinPullup_d; // combinational pull-up request

	// only pin5 has a pull-up; config, global bit and direction gate it
	always @* begin
		pinPullup_d = 8'h00;
		if (pinDirOutput[`PALP_PIN5]) begin
			// driven pin: pull-up forced off
			pinPullup_d[`PALP_PIN5] = 1'b0; // RQ7 RQ9
		end else if (extResetSync) begin
			// reset function owns pin5: pull-up always on
			pinPullup_d[`PALP_PIN5] = 1'b1; // RQ5
		end else if (!globalPullupOff_q) begin
			// software bit decides
			pinPullup_d[`PALP_PIN5] = pullupEnableReg_q[`PALP_PIN5]; // RQ4 RQ6
		end
	end

	// register the pull-up drive so the pad sees clean levels
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pinPullup_q <= 8'h00;
		end else begin
			pinPullup_q <= pinPullup_d;
		end
	end

	assign pinPullup = pinPullup_q;

	////////////////////////////////////////////////////////////////
	// pin drive
	////////////////////////////////////////////////////////////////

	// latch drives pins; pin5 has no latch so never drives
	assign pinOut = outputLatchReg_q;
	assign pinOe = pinDirOutput & `PALP_LATCH_MASK;

	////////////////////////////////////////////////////////////////
	// read channel
	////////////////////////////////////////////////////////////////

	wire arFire; // read address taken
	wire [2:0] rdIdx; // decoded read target
	reg [31:0] rdMux; // selected read value

	assign s_axi_arready = ~rvalid_q;
	assign arFire = s_axi_arvalid & s_axi_arready;
	assign rdIdx = decodeIdx(s_axi_araddr);

	// select the read value; narrow registers sit in low bits
	always @* begin
		rdMux = 32'h00000000;
		if (rdIdx == IDX_PIN_VIEW) begin
			rdMux[7:0] = pinLevel; // RQ2
		end else if (rdIdx == IDX_LATCH) begin
			rdMux[7:0] = outputLatchReg_q; // RQ3
		end else if (rdIdx == IDX_PULLUP) begin
			rdMux[7:0] = pullupEnableReg_q; // RQ8
		end else if (rdIdx == IDX_CTRL) begin
			rdMux[`PALP_CTRL_GLOBAL_OFF] = globalPullupOff_q;
		end else if (rdIdx == IDX_STATUS) begin
			rdMux[7:0] = pinPullup_q;
			rdMux[`PALP_STAT_EXT_RESET] = extResetSync;
		end
	end

	// one read at a time; data held until rready
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `PALP_RESP_OKAY;
		end else if (arFire) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdMux;
			rresp_q <= (rdIdx == IDX_NONE) ? `PALP_RESP_SLVERR : `PALP_RESP_OKAY;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

// File: testbench/palp_checker.sv
`timescale 1ns/1ps
// pin and handshake watcher
module palp_checker (
	input wire mclk,
	input wire rstn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] pinOut,
	input wire [7:0] pinOe,
	input wire [7:0] pinPullup,
	input wire [7:0] pinDirOutput,
	input wire extResetPinEnable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// config held through the sync stages
	sequence extHeld;
		extResetPinEnable[*4] ##0 !pinDirOutput[5];
	endsequence
	// both write halves taken at once
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	pin5_low_a: assert property (pinOut[5] == 1'h0) else $error("pin5 driven");
	oe_mask_a: assert property (pinOe == (pinDirOutput & 8'hdf)) else $error("oe mismatch");
	pullup_bits_a: assert property ((pinPullup & 8'hdf) == 8'h00) else $error("stray pullup");
	dir_kill_a: assert property (pinDirOutput[5] |=> !pinPullup[5]) else $error("pullup on output");
	ext_force_a: assert property (extHeld |=> pinPullup[5]) else $error("pullup not forced");
	wr_resp_a: assert property (wrTaken |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind palp_port palp_checker palp_checker_i (.*);

// File: testbench/palp_board.sv
`timescale 1ns/1ps
// board side: drives, pull-ups, floating pins
module palp_board (
	input wire mclk,
	input wire [7:0] pinOut,
	input wire [7:0] pinOe,
	input wire [7:0] pinPullup,
	input wire [7:0] extDrv,
	input wire [7:0] extEn,
	output wire [7:0] pinIn
);
	logic toggle_q = 1'h0; // undriven pins without pull-up flip every cycle
	always @(posedge mclk) toggle_q <= ~toggle_q;
	// chip drive wins, then board drive, then pull-up
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extDrv) | (~pinOe & ~extEn & (pinPullup | {8{toggle_q}}));
endmodule

// File: testbench/port_a_latch_and_pullup_test.sv
`timescale 1ns/1ps
`include "palp_regs.vh"
module port_a_latch_and_pullup_test;
	logic mclk = 1'h0, rstn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [7:0] pinDirOutput = 8'h00, extDrv = 8'h00, extEn = 8'h00;
	logic extResetPinEnable = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] pinIn, pinOut, pinOe, pinPullup;
	int err_count = 0, samples_checked = 0;
	always #25 mclk = ~mclk;
	palp_port palp_port_i (.*);
	palp_board palp_board_i (.*);
	////////////////////////////////////////////////////////////
	// compare and report
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bus write, bready held back st cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input int st, output logic [1:0] r);
		int n = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= (st == 0);
		do begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (n++ >= st) s_axi_bready <= 1'h1;
		end while (!(s_axi_bvalid && s_axi_bready));
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// bus read, rready held back st cycles
	task automatic rd(input logic [7:0] a, input int st, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= (st == 0);
		do begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (n++ >= st) s_axi_rready <= 1'h1;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input int st);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, st, d, r);
		chk(d, e);
		chk({30'h0, r}, {30'h0, `PALP_RESP_OKAY});
	endtask
	task automatic wok(input logic [7:0] a, input logic [31:0] d, input int st);
		logic [1:0] r;
		wr(a, d, st, r);
		chk({30'h0, r}, {30'h0, `PALP_RESP_OKAY});
	endtask
	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////
	// reset values
	task tReset;
		chk({24'h0, pinOut}, 32'h0);
		rchk(`PALP_OFF_LATCH, 32'h0, 0);
		rchk(`PALP_OFF_PULLUP, 32'h20, 2);
		rchk(`PALP_OFF_CTRL, 32'h1, 0);
		$display("reset test done");
	endtask
	// pin-view writes land in the latch
	task tLatch;
		pinDirOutput <= 8'hff;
		wok(`PALP_OFF_PIN_VIEW, 32'hff, 2);
		rchk(`PALP_OFF_LATCH, 32'hdf, 0);
		chk({24'h0, pinOut}, 32'hdf);
		wok(`PALP_OFF_LATCH, 32'h8a, 0);
		$display("latch test done");
	endtask
	// pin-view reads show live pins
	task tPins;
		extEn <= 8'h20;
		extDrv <= 8'h20;
		wt(4);
		rchk(`PALP_OFF_PIN_VIEW, 32'haa, 0);
		rchk(`PALP_OFF_LATCH, 32'h8a, 0);
		pinDirOutput <= 8'h00;
		extEn <= 8'hff;
		extDrv <= 8'h55;
		wt(4);
		rchk(`PALP_OFF_PIN_VIEW, 32'h55, 3);
		$display("pin test done");
	endtask
	// pull-up gating
	task tPullup;
		extEn <= 8'h00;
		wt(4);
		chk({24'h0, pinPullup}, 32'h0);
		wok(`PALP_OFF_CTRL, 32'h0, 0);
		wt(2);
		chk({24'h0, pinPullup}, 32'h20);
		rchk(`PALP_OFF_STATUS, 32'h20, 0);
		wok(`PALP_OFF_PULLUP, 32'hff, 0);
		rchk(`PALP_OFF_PULLUP, 32'h20, 0);
		wok(`PALP_OFF_PULLUP, 32'h0, 0);
		wt(2);
		chk({24'h0, pinPullup}, 32'h0);
		wok(`PALP_OFF_PULLUP, 32'h20, 0);
		pinDirOutput <= 8'h20;
		wt(2);
		chk({24'h0, pinPullup}, 32'h0);
		pinDirOutput <= 8'h00;
		wt(2);
		chk({24'h0, pinPullup}, 32'h20);
		$display("pullup test done");
	endtask
	// reset-pin config forces pull-up
	task tExt;
		wok(`PALP_OFF_PULLUP, 32'h0, 0);
		wok(`PALP_OFF_CTRL, 32'h1, 0);
		extResetPinEnable <= 1'h1;
		wt(5);
		chk({24'h0, pinPullup}, 32'h20);
		rchk(`PALP_OFF_STATUS, 32'h120, 0);
		$display("ext test done");
	endtask
	// unmapped place refused
	task tBad;
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h14, 32'hff, 0, r);
		chk({30'h0, r}, {30'h0, `PALP_RESP_SLVERR});
		rd(8'h14, 0, d, r);
		chk({30'h0, r}, {30'h0, `PALP_RESP_SLVERR});
		chk(d, 32'h0);
		// byte lane 0 strobe low: write answered but latch kept
		s_axi_wstrb <= 4'he;
		wok(`PALP_OFF_LATCH, 32'h00, 0);
		s_axi_wstrb <= 4'hf;
		rchk(`PALP_OFF_LATCH, 32'h8a, 0);
		$display("unmapped test done");
	endtask
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'h1;
		tReset;
		tLatch;
		tPins;
		tPullup;
		tExt;
		tBad;
		summarize;
	end
	// watchdog
	initial begin
		#200000;
		err_count++;
		summarize;
	end
endmodule
